// ==== inc/lapt_pkg.sv ====
package lapt_pkg;

    // ------------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------------
    localparam int unsigned CORE_CLOCK_FREQUENCY = 20_000_000;
    localparam int unsigned US_PER_SECOND = 1_000_000;
    // Prescale divisor minus one, so that one count equals one microsecond.
    localparam logic [15:0] US_PRESCALE = 16'(CORE_CLOCK_FREQUENCY / US_PER_SECOND - 1);
    // The microsecond counter restarts after this many ticks.
    localparam logic [31:0] US_PERIOD = 32'(US_PER_SECOND);
    // The seconds counter wraps above this value.
    localparam logic [31:0] SEC_MAX = 32'hFFFFFFFF;
    localparam logic [15:0] SEC_PRESCALE = 16'h0000;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PRESC = 8'h04;
    localparam logic [7:0] REG_RELOAD = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0C;
    localparam logic [7:0] REG_SECONDS = 8'h10;
    localparam logic [7:0] REG_MICROS = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_MASK = 8'h1C;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned ST_TICK_BIT = 0;
    localparam int unsigned ST_SECOND_BIT = 1;
    localparam int unsigned ST_WIDTH = 2;
    localparam logic [15:0] PRESC_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'hFFFF;
    localparam logic [1:0] MASK_RESET = 2'h0;

    // Periodic timer state.
    typedef enum logic [1:0] {
        LAPT_IDLE = 2'b00,
        LAPT_LOAD = 2'b01,
        LAPT_RUN = 2'b10
    } lapt_state_e;

endpackage

// ==== rtl/lapt_prescaler.sv ====
`timescale 1ns/1ps

// Programmable divider: emits a one-cycle pulse every (divide + 1) enabled cycles.
module lapt_prescaler (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    input wire logic enable,
    input wire logic restart,
    input wire logic [15:0] divide,
    // Output
    output logic pulse
);

    logic [15:0] count_r;

    // Count up to the divisor and restart; restart realigns the phase.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_r <= 16'h0000;
        end else if (restart || !enable) begin
            count_r <= 16'h0000;
        end else if (count_r >= divide) begin
            count_r <= 16'h0000;
        end else begin
            count_r <= count_r + 16'h0001;
        end
    end

    assign pulse = enable && !restart && (count_r >= divide);

endmodule

// ==== rtl/lapt_timer.sv ====
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps

module lapt_timer (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Events
    output logic measureTick,
    output logic irq
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic ack_r;
    logic [31:0] rdata_r;
    logic access;
    logic wrStb;
    logic rdStb;

    // One-cycle answer; ack drops the cycle after it was given.
    assign access = wb_cyc_i && wb_stb_i && !ack_r;
    assign wrStb = access && wb_we_i;
    assign rdStb = access && !wb_we_i;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= access;
        end
    end

    // ------------------------------------------------------------------
    // Lifetime counter: microseconds and seconds
    // ------------------------------------------------------------------
    logic usTick;
    logic [31:0] micros_r;
    logic [31:0] seconds_r;
    logic [31:0] microsSnap_r;
    logic secTrigger;

    // Fixed prescaler turns the core clock into a microsecond enable.
    lapt_prescaler u_us_prescaler (
        .clock(clock),
        .rst(rst),
        .enable(1'b1),
        .restart(1'b0),
        .divide(lapt_pkg::US_PRESCALE),
        .pulse(usTick)
    );

    // Trigger fires on the tick that takes the counter back to zero.
    assign secTrigger = usTick && (micros_r == lapt_pkg::US_PERIOD - 32'h00000001);

    // Microsecond counter counts up and restarts after one second.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            micros_r <= 32'h00000000;
        end else if (secTrigger) begin
            micros_r <= 32'h00000000;
        end else if (usTick) begin
            micros_r <= micros_r + 32'h00000001;
        end
    end

    // Seconds counter is a slave of the microsecond trigger; it wraps naturally.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            seconds_r <= 32'h00000000;
        end else if (secTrigger) begin
            if (seconds_r == lapt_pkg::SEC_MAX) begin
                seconds_r <= 32'h00000000;
            end else begin
                seconds_r <= seconds_r + 32'h00000001;
            end
        end
    end

    // Reading seconds freezes the microseconds of that same cycle, so software
    // reads seconds first and then the snapshot; no wrap can split the pair.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            microsSnap_r <= 32'h00000000;
        end else if (rdStb && wb_adr_i == lapt_pkg::REG_SECONDS) begin
            microsSnap_r <= micros_r;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic enable_r;
    logic [15:0] presc_r;
    logic [15:0] reload_r;
    logic [1:0] mask_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enable_r <= 1'b0;
            presc_r <= lapt_pkg::PRESC_RESET;
            reload_r <= lapt_pkg::RELOAD_RESET;
            mask_r <= lapt_pkg::MASK_RESET;
        end else if (wrStb) begin
            case (wb_adr_i)
                lapt_pkg::REG_CTRL: begin
                    if (wb_sel_i[0]) begin
                        enable_r <= wb_dat_i[lapt_pkg::CTRL_ENABLE_BIT];
                    end
                end
                lapt_pkg::REG_PRESC: begin
                    if (wb_sel_i[0]) begin
                        presc_r[7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        presc_r[15:8] <= wb_dat_i[15:8];
                    end
                end
                lapt_pkg::REG_RELOAD: begin
                    if (wb_sel_i[0]) begin
                        reload_r[7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        reload_r[15:8] <= wb_dat_i[15:8];
                    end
                end
                lapt_pkg::REG_MASK: begin
                    if (wb_sel_i[0]) begin
                        mask_r <= wb_dat_i[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Periodic tick timer
    // ------------------------------------------------------------------
    lapt_pkg::lapt_state_e state_r;
    logic [15:0] count_r;
    logic [15:0] activePresc_r;
    logic [15:0] activeReload_r;
    logic pitTick;
    logic pitZero;

    // Settings are copied at activation, so writes while running take effect
    // only on the next enable; this keeps a running period stable.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= lapt_pkg::LAPT_IDLE;
            activePresc_r <= lapt_pkg::PRESC_RESET;
            activeReload_r <= lapt_pkg::RELOAD_RESET;
        end else begin
            case (state_r)
                lapt_pkg::LAPT_IDLE: begin
                    if (enable_r) begin
                        activePresc_r <= presc_r;
                        activeReload_r <= reload_r;
                        state_r <= lapt_pkg::LAPT_LOAD;
                    end
                end
                lapt_pkg::LAPT_LOAD: begin
                    state_r <= enable_r ? lapt_pkg::LAPT_RUN : lapt_pkg::LAPT_IDLE;
                end
                lapt_pkg::LAPT_RUN: begin
                    if (!enable_r) begin
                        state_r <= lapt_pkg::LAPT_IDLE;
                    end
                end
                default: begin
                    state_r <= lapt_pkg::LAPT_IDLE;
                end
            endcase
        end
    end

    lapt_prescaler u_pit_prescaler (
        .clock(clock),
        .rst(rst),
        .enable(state_r == lapt_pkg::LAPT_RUN),
        .restart(1'b0),
        .divide(activePresc_r),
        .pulse(pitTick)
    );

    assign pitZero = pitTick && (count_r == 16'h0000);

    // Down-counter: loads at activation, reloads after each zero.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_r <= 16'h0000;
        end else if (state_r == lapt_pkg::LAPT_LOAD) begin
            count_r <= activeReload_r;
        end else if (pitZero) begin
            count_r <= activeReload_r;
        end else if (pitTick) begin
            count_r <= count_r - 16'h0001;
        end
    end

    assign measureTick = pitZero;

    // ------------------------------------------------------------------
    // Interrupt status, cleared by reading it; a new event wins.
    // ------------------------------------------------------------------
    logic [1:0] status_r;
    logic [1:0] events;

    assign events = {secTrigger, pitZero};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status_r <= 2'h0;
        end else if (rdStb && wb_adr_i == lapt_pkg::REG_STATUS) begin
            status_r <= events;
        end else begin
            status_r <= status_r | events;
        end
    end

    assign irq = |(status_r & mask_r);

    // ------------------------------------------------------------------
    // Read data; unmapped offsets read zero.
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_r <= 32'h00000000;
        end else if (rdStb) begin
            case (wb_adr_i)
                lapt_pkg::REG_CTRL: rdata_r <= {31'h0, enable_r};
                lapt_pkg::REG_PRESC: rdata_r <= {16'h0000, presc_r};
                lapt_pkg::REG_RELOAD: rdata_r <= {16'h0000, reload_r};
                lapt_pkg::REG_COUNT: rdata_r <= {16'h0000, count_r};
                lapt_pkg::REG_SECONDS: rdata_r <= seconds_r;
                lapt_pkg::REG_MICROS: rdata_r <= microsSnap_r;
                lapt_pkg::REG_STATUS: rdata_r <= {30'h0, status_r};
                lapt_pkg::REG_MASK: rdata_r <= {30'h0, mask_r};
                default: rdata_r <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertion helpers
    // ------------------------------------------------------------------
    // Gap counters stand in for long repetitions, which the property tools
    // would have to unroll; the assertions then compare a single value.
    logic [15:0] usGap_r;
    logic [15:0] pitGap_r;
    logic stRead;
    logic secRead;

    // Strobes of the two reads that have side effects.
    assign stRead = rdStb && wb_adr_i == lapt_pkg::REG_STATUS;
    assign secRead = rdStb && wb_adr_i == lapt_pkg::REG_SECONDS;

    // Cycles since the last microsecond tick.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            usGap_r <= 16'h0000;
        end else if (usTick) begin
            usGap_r <= 16'h0000;
        end else begin
            usGap_r <= usGap_r + 16'h0001;
        end
    end

    // Cycles since the last periodic tick, counted only while running.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pitGap_r <= 16'h0000;
        end else if (state_r != lapt_pkg::LAPT_RUN || pitTick) begin
            pitGap_r <= 16'h0000;
        end else begin
            pitGap_r <= pitGap_r + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_us_wrap: assert property (secTrigger |=> micros_r == 32'h00000000)
        else $error("microsecond counter did not restart");
    a_us_step: assert property (usTick && !secTrigger |=> micros_r == $past(micros_r) + 32'h00000001)
        else $error("microsecond counter did not step");
    a_us_bound: assert property (micros_r < lapt_pkg::US_PERIOD)
        else $error("microsecond counter out of range");
    a_tick_spacing: assert property (usTick |-> usGap_r == lapt_pkg::US_PRESCALE)
        else $error("microsecond tick spacing wrong");
    a_tick_bound: assert property (usGap_r <= lapt_pkg::US_PRESCALE)
        else $error("microsecond tick overdue");
    a_sec_step: assert property (secTrigger |=> seconds_r == $past(seconds_r) + 32'h00000001)
        else $error("seconds did not advance on trigger");
    a_sec_hold: assert property (!secTrigger |=> $stable(seconds_r))
        else $error("seconds moved without trigger");
    a_trig_cause: assert property (secTrigger |-> usTick && micros_r == lapt_pkg::US_PERIOD - 32'h00000001)
        else $error("trigger without wrap");
    a_pit_load: assert property (state_r == lapt_pkg::LAPT_LOAD |=> count_r == $past(activeReload_r))
        else $error("periodic timer not loaded");
    a_pit_down: assert property (pitTick && count_r != 16'h0000 |=> count_r == $past(count_r) - 16'h0001)
        else $error("periodic timer not counting down");
    a_pit_irq: assert property (pitZero |=> status_r[lapt_pkg::ST_TICK_BIT])
        else $error("zero did not set status");
    a_snap_pair: assert property (secRead |=> microsSnap_r == $past(micros_r))
        else $error("snapshot not from same instant");
    a_snap_hold: assert property (!secRead |=> $stable(microsSnap_r))
        else $error("snapshot changed without seconds read");
    a_pit_spacing: assert property (pitTick |-> pitGap_r == activePresc_r)
        else $error("periodic prescale spacing wrong");
    a_pit_reload: assert property (pitZero |=> count_r == $past(activeReload_r))
        else $error("periodic timer not reloaded at zero");
    a_pit_stop: assert property (!enable_r ##1 !enable_r |-> !measureTick)
        else $error("periodic tick while disabled");
    a_status_clear: assert property (stRead && !pitZero |=> !status_r[lapt_pkg::ST_TICK_BIT])
        else $error("status read did not clear");
    a_status_sticky: assert property (!stRead |=> (status_r & $past(status_r)) == $past(status_r))
        else $error("status bit lost without read");

    c_second_wrap: cover property (secTrigger);
    c_pit_zero: cover property (pitZero);
    c_irq_high: cover property (irq);
    c_bus_read: cover property (rdStb ##1 wb_ack_o);

endmodule

// ==== verif/lapt_tb.sv ====
`timescale 1ns/1ps

module testbench;

    // ------------------------------------------------------------------
    // Signals and bookkeeping
    // ------------------------------------------------------------------
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatW = 32'h00000000;
    logic [31:0] wbDatR;
    logic wbAck;
    logic measureTick;
    logic irq;
    int miscompares = 0;
    int compares = 0;
    int cyc = 0;
    int guard = 0;
    int lastTick = 0;
    bit tickValid = 1'b0;
    longint rdLoQ[$];
    longint rdHiQ[$];
    int perQ[$];
    // Reset table: CTRL, PRESC, RELOAD, STATUS, MASK and one unmapped word.
    logic [7:0] rstAdr [6] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h1C, 8'h20};
    logic [31:0] rstVal [6] = '{32'h0, 32'h0, 32'h0000FFFF, 32'h0, 32'h0, 32'h0};

    // The clock toggles every half period of 25 ns.
    always #25 clock = ~clock;

    lapt_timer lapt_timer_i (
        .clock(clock),
        .rst(rst),
        .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb),
        .wb_we_i(wbWe),
        .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel),
        .wb_dat_i(wbDatW),
        .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck),
        .measureTick(measureTick),
        .irq(irq)
    );

    // ------------------------------------------------------------------
    // Reporting and compare tasks
    // ------------------------------------------------------------------
    task automatic report(input string m);
        miscompares++;
        $display("[ERR] %0t %s", $time, m);
    endtask

    task automatic print_verdict();
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Read data must fall inside a window; an unknown bit never passes.
    task automatic chk_rd(input logic [31:0] got, input longint lo, input longint hi);
        compares++;
        if ($isunknown(got) || longint'(got) < lo || longint'(got) > hi) begin
            report($sformatf("read %h outside %0d..%0d", got, lo, hi));
        end
    endtask

    task automatic chk_per(input int got, input int exp);
        compares++;
        if (got != exp) begin
            report($sformatf("tick period %0d expected %0d", got, exp));
        end
    endtask

    task automatic chk_irq(input logic exp);
        compares++;
        if (irq !== exp) begin
            report("interrupt level wrong");
        end
    endtask

    // ------------------------------------------------------------------
    // Bus master
    // ------------------------------------------------------------------
    // The request is held until ack is sampled high, then dropped; the next call
    // waits one edge first, so strobe stays low for at least one cycle.
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbSel <= 4'hF;
        wbDatW <= d;
        do @(posedge clock); while (wbAck !== 1'b1);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    task automatic wb_rd(input logic [7:0] a, input longint lo, input longint hi);
        rdLoQ.push_back(lo);
        rdHiQ.push_back(hi);
        wb_xfer(1'b0, a, 32'h0);
    endtask

    // ------------------------------------------------------------------
    // Watchers
    // ------------------------------------------------------------------
    // Read data is taken at the very edge where ack is sampled.
    always @(posedge clock) begin
        if (wbAck === 1'b1 && wbWe === 1'b0) begin
            if (rdLoQ.size() == 0) begin
                report("unexpected read answer");
            end else begin
                chk_rd(wbDatR, rdLoQ.pop_front(), rdHiQ.pop_front());
            end
        end
    end

    // Cycle count since reset, tick spacing and the hang limit.
    always @(posedge clock) begin
        cyc <= rst ? 0 : cyc + 1;
        guard <= guard + 1;
        if (measureTick === 1'b1) begin
            if (tickValid && perQ.size() > 0) begin
                chk_per(cyc - lastTick, perQ.pop_front());
            end
            lastTick = cyc;
            tickValid = 1'b1;
        end
        if (guard > 60000) begin
            report("timeout");
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int c;
        logic [15:0] pr;
        logic [15:0] rl;
        void'($urandom(12));
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        // Reset values, including an unmapped word that reads zero.
        foreach (rstAdr[i]) begin
            wb_rd(rstAdr[i], rstVal[i], rstVal[i]);
        end
        // Lifetime pair: the second read must show the instant of the first.
        // Later windows only rise, so a smaller reading would be a wrap that
        // the single-counter reader has to correct.
        for (int g = 0; g < 2; g++) begin
            repeat (300 + g * 700) @(posedge clock);
            wb_rd(lapt_pkg::REG_SECONDS, 0, 0);
            c = cyc;
            repeat (g * 100) @(posedge clock);
            wb_rd(lapt_pkg::REG_MICROS, c / 20 - 2, c / 20 + 1);
        end
        // Periodic timer with random prescale and reload, three spacings each.
        for (int k = 0; k < 3; k++) begin
            pr = 16'($urandom_range(3, 0));
            rl = 16'($urandom_range(20, 3));
            wb_xfer(1'b1, lapt_pkg::REG_CTRL, 32'h0);
            wb_xfer(1'b1, lapt_pkg::REG_PRESC, {16'h0000, pr});
            wb_xfer(1'b1, lapt_pkg::REG_RELOAD, {16'h0000, rl});
            wb_rd(lapt_pkg::REG_RELOAD, rl, rl);
            tickValid = 1'b0;
            repeat (3) perQ.push_back((int'(rl) + 1) * (int'(pr) + 1));
            wb_xfer(1'b1, lapt_pkg::REG_CTRL, 32'h1);
            wb_rd(lapt_pkg::REG_COUNT, 0, rl);
            while (perQ.size() > 0) @(posedge clock);
        end
        // Interrupt: masked, unmasked, then cleared by a status read.
        wb_xfer(1'b1, lapt_pkg::REG_MASK, 32'h0);
        @(posedge clock iff measureTick === 1'b1);
        repeat (2) @(posedge clock);
        chk_irq(1'b0);
        wb_xfer(1'b1, lapt_pkg::REG_MASK, 32'h1);
        repeat (2) @(posedge clock);
        chk_irq(1'b1);
        wb_xfer(1'b1, lapt_pkg::REG_CTRL, 32'h0);
        wb_rd(lapt_pkg::REG_STATUS, 1, 1);
        wb_rd(lapt_pkg::REG_STATUS, 0, 0);
        repeat (2) @(posedge clock);
        chk_irq(1'b0);
        print_verdict();
    end

endmodule
